// ===== hw/lpm_pkg.sv
// Package for the low-power mode controller: register map, field layout, timing.
// Assumes a single 25 MHz system clock and an SFR-style byte access port.
package lpm_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] LPM_PWR_CTRL_ADDR = 8'h87;
    localparam logic [7:0] LPM_PWR_CTRL_RESET = 8'h00;
    localparam int LPM_SLEEP_BIT = 0;
    localparam int LPM_HALT_BIT = 1;
    localparam int LPM_FLAGS_LSB = 2;
    localparam int LPM_FLAGS_W = 6;
    localparam logic [15:0] LPM_RESET_VECTOR = 16'h0000;
    // ==========================================
    // Timing
    localparam int LPM_CLK_MHZ = 25;
    localparam int LPM_LOST_CLK_US = 100;
    localparam int LPM_LOST_CLK_CYCLES = LPM_LOST_CLK_US * LPM_CLK_MHZ;
    localparam int LPM_WDOG_DIV = 12;
    localparam int LPM_WDOG_DIV_W = 4;
    localparam logic [3:0] LPM_WDOG_DIV_LAST = 4'(LPM_WDOG_DIV - 1);
    // ==========================================
    // Power states, one-hot
    typedef enum logic [2:0] {
        LPM_RUN = 3'b001,
        LPM_SLEEP = 3'b010,
        LPM_HALT = 3'b100
    } lpm_state_type;
endpackage

// ===== hw/lpm_power_ctrl.sv
// Low-power mode controller: power control register, light sleep and deep halt.
// Assumes the core pulses sfr_wr_in and insn_done_in on clk_in; enables are core logic.
`timescale 1ns/1ps

// Function
// R1 - Sleep starts only once the instruction writing the sleep bit completes.
// R2 - Light sleep gates only the CPU clock; peripherals keep their clock.
// R3 - Light sleep never alters any register or memory content.
// R4 - Enabled interrupt clears sleep, resumes CPU, services interrupt, then continues.
// R5 - Reset ends light sleep with normal reset sequence, fetch from 0x0000.
// R6 - Enabled watchdog keeps counting in sleep and resets on expiry.
// R7 - Software follows the sleep-setting instruction with a multi-byte instruction.
// R8 - Halt bit enters deep halt after instruction; stops oscillator, CPU, peripherals.
// R9 - In deep halt only the lost clock detector stays active.
// R10 - Deep halt ends only by reset, never interrupt; restart at 0x0000.
// R11 - Enabled lost clock detector resets the chip during deep halt.
// R12 - Software disables lost clock detector before halts over 100 us.
// R13 - Halt and sleep bits always read as zero.
// R14 - Upper six bits are plain software read/write flags.
// R15 - Writing both halt and sleep together enters deep halt.
module lpm_power_ctrl
    import lpm_pkg::*;
#(
    parameter int WDOG_W = 16,
    parameter int LOST_CLK_CYCLES = lpm_pkg::LPM_LOST_CLK_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // SFR access port from the core
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // Core handshake
    input wire logic insn_done_in,
    input wire logic irq_pending_in,
    // Reset sources
    input wire logic ext_reset_in,
    input wire logic wdog_enable_in,
    input wire logic lost_clk_enable_in,
    // Clock gates and reset request
    output logic cpu_clk_en_out,
    output logic periph_clk_en_out,
    output logic int_osc_en_out,
    output logic sys_reset_out,
    output logic [15:0] reset_vector_out,
    output logic [2:0] power_state_out
);
    import lpm_pkg::*;

    initial begin
        if (LOST_CLK_CYCLES < 2) $error("LOST_CLK_CYCLES too small");
    end

    // ==========================================
    // State
    typedef struct packed {
        lpm_state_type state;
        logic [LPM_FLAGS_W-1:0] flags;
        logic sleep_arm;
        logic halt_arm;
        logic [LPM_WDOG_DIV_W-1:0] div;
        logic [31:0] lost_cnt;
        logic ext_s1;
        logic ext_s2;
        logic reset_req;
        logic [7:0] rdata;
        logic cpu_en;
        logic per_en;
        logic osc_en;
    } lpm_ctrl_type;

    lpm_ctrl_type st_reg;
    lpm_ctrl_type st_next;
    logic wd_tick;
    logic wd_expired;
    logic write_hit;

    lpm_wake_if wake ();

    assign write_hit = sfr_wr_in && (sfr_addr_in == LPM_PWR_CTRL_ADDR);
    assign wake.tick = wd_tick;
    assign wake.halted = (st_reg.state == LPM_HALT);
    assign wake.enable = wdog_enable_in;
    assign wd_expired = wake.expired;
    assign wd_tick = (st_reg.div == LPM_WDOG_DIV_LAST);

    lpm_watchdog #(
        .COUNT_W(WDOG_W)
    ) u_wdog (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .wake(wake)
    );

    always_comb begin
        st_next = st_reg;
        st_next.ext_s1 = ext_reset_in;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.reset_req = 1'b0;
        // Watchdog divider runs on the system clock; it stops with the oscillator
        if (st_reg.state != LPM_HALT) begin
            st_next.div = wd_tick ? '0 : st_reg.div + 1'b1;
        end
        // Register write: flags stored, mode bits only armed [R14]
        if (write_hit) begin
            st_next.flags = sfr_wdata_in[LPM_FLAGS_LSB +: LPM_FLAGS_W]; // [R14]
            st_next.halt_arm = st_reg.halt_arm | sfr_wdata_in[LPM_HALT_BIT];
            st_next.sleep_arm = st_reg.sleep_arm | sfr_wdata_in[LPM_SLEEP_BIT];
        end
        case (st_reg.state)
            LPM_RUN: begin
                // Entry waits for the writing instruction to finish [R1] [R8]
                if (insn_done_in && (st_next.halt_arm || st_next.sleep_arm)) begin
                    st_next.state = st_next.halt_arm ? LPM_HALT : LPM_SLEEP; // [R15]
                    st_next.halt_arm = 1'b0;
                    st_next.sleep_arm = 1'b0;
                end
            end
            LPM_SLEEP: begin
                if (irq_pending_in) begin
                    st_next.state = LPM_RUN; // [R4]
                end
            end
            LPM_HALT: begin
                // Interrupts ignored here; only a reset gets out [R10]
                if (lost_clk_enable_in) begin
                    st_next.lost_cnt = st_reg.lost_cnt + 32'd1; // [R11]
                end
            end
            default: begin
                st_next.state = LPM_RUN;
            end
        endcase
        if (st_reg.state != LPM_HALT) begin
            st_next.lost_cnt = '0;
        end
        // Reset sources end either low-power state [R5] [R6] [R10] [R11]
        if (st_reg.ext_s2 || wd_expired
            || (st_reg.lost_cnt >= 32'(LOST_CLK_CYCLES - 1))) begin
            st_next.reset_req = 1'b1;
            st_next.state = LPM_RUN;
            st_next.lost_cnt = '0;
            st_next.halt_arm = 1'b0;
            st_next.sleep_arm = 1'b0;
        end
        st_next.cpu_en = (st_next.state == LPM_RUN); // [R2]
        st_next.per_en = (st_next.state != LPM_HALT); // [R2] [R9]
        st_next.osc_en = (st_next.state != LPM_HALT); // [R8]
        // Mode bits always read back as zero [R13]
        st_next.rdata = {st_next.flags, 2'b00}; // [R13]
    end

    // Storage elsewhere is untouched: this block only gates clocks [R3]
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg.state <= LPM_RUN;
            st_reg.flags <= LPM_PWR_CTRL_RESET[LPM_FLAGS_LSB +: LPM_FLAGS_W];
            st_reg.sleep_arm <= 1'b0;
            st_reg.halt_arm <= 1'b0;
            st_reg.div <= '0;
            st_reg.lost_cnt <= '0;
            st_reg.ext_s1 <= 1'b0;
            st_reg.ext_s2 <= 1'b0;
            st_reg.reset_req <= 1'b0;
            st_reg.rdata <= LPM_PWR_CTRL_RESET;
            st_reg.cpu_en <= 1'b1;
            st_reg.per_en <= 1'b1;
            st_reg.osc_en <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sfr_rdata_out = st_reg.rdata;
    assign cpu_clk_en_out = st_reg.cpu_en;
    assign periph_clk_en_out = st_reg.per_en;
    assign int_osc_en_out = st_reg.osc_en;
    assign sys_reset_out = st_reg.reset_req;
    assign reset_vector_out = LPM_RESET_VECTOR; // [R5] [R10]
    assign power_state_out = st_reg.state;

    // ==========================================
    // Checks
    sequence s_arm_done;
        insn_done_in && st_reg.state == LPM_RUN && (st_next.halt_arm || st_next.sleep_arm);
    endsequence

    property p_enter_after_insn;
        @(posedge clk_in) disable iff (!rstn_in)
        (st_reg.state == LPM_RUN && !insn_done_in && !sys_reset_out)
            |=> (st_reg.state == LPM_RUN) || $past(st_reg.ext_s2) || $past(wd_expired);
    endproperty
    a_enter_after_insn: assert property (p_enter_after_insn) // [R1]
        else $error("power state left run without instruction completion");

    property p_sleep_gating;
        @(posedge clk_in) disable iff (!rstn_in)
        (st_reg.state == LPM_SLEEP) |-> (!cpu_clk_en_out && periph_clk_en_out && int_osc_en_out);
    endproperty
    a_sleep_gating: assert property (p_sleep_gating) // [R2]
        else $error("sleep clock gating wrong");

    property p_irq_wake;
        @(posedge clk_in) disable iff (!rstn_in)
        (st_reg.state == LPM_SLEEP && irq_pending_in)
            |=> (cpu_clk_en_out && st_reg.state == LPM_RUN);
    endproperty
    a_irq_wake: assert property (p_irq_wake) // [R4]
        else $error("interrupt did not wake from sleep");

    property p_halt_ignores_irq;
        @(posedge clk_in) disable iff (!rstn_in)
        (st_reg.state == LPM_HALT && !st_reg.ext_s2 && !wd_expired
            && st_reg.lost_cnt < 32'(LOST_CLK_CYCLES - 1)) |=> (st_reg.state == LPM_HALT);
    endproperty
    a_halt_ignores_irq: assert property (p_halt_ignores_irq) // [R10]
        else $error("deep halt left without reset");

    property p_halt_gating;
        @(posedge clk_in) disable iff (!rstn_in)
        (st_reg.state == LPM_HALT) |-> !(cpu_clk_en_out || periph_clk_en_out || int_osc_en_out);
    endproperty
    a_halt_gating: assert property (p_halt_gating) // [R8]
        else $error("deep halt did not stop clocks");

    // Cycles halted with the detector on; a counter stands in for a long delay range
    logic [31:0] lost_watch_reg;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lost_watch_reg <= '0;
        end else if (st_reg.state == LPM_HALT && lost_clk_enable_in) begin
            lost_watch_reg <= lost_watch_reg + 32'd1;
        end else begin
            lost_watch_reg <= '0;
        end
    end

    property p_lost_clk_reset;
        @(posedge clk_in) disable iff (!rstn_in)
        (st_reg.state == LPM_HALT && lost_clk_enable_in
            && lost_watch_reg == 32'(LOST_CLK_CYCLES - 1)) |=> sys_reset_out;
    endproperty
    a_lost_clk_reset: assert property (p_lost_clk_reset) // [R11]
        else $error("lost clock detector did not reset halt");

    property p_ext_reset;
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(st_reg.ext_s2) |=> (sys_reset_out && st_reg.state == LPM_RUN);
    endproperty
    a_ext_reset: assert property (p_ext_reset) // [R5]
        else $error("external reset did not end low-power state");

    property p_read_zero;
        @(posedge clk_in) disable iff (!rstn_in)
        sfr_rdata_out[1:0] == 2'b00;
    endproperty
    a_read_zero: assert property (p_read_zero) // [R13]
        else $error("mode bits read nonzero");

    property p_flags_store;
        @(posedge clk_in) disable iff (!rstn_in)
        write_hit |=> (sfr_rdata_out[7:2] == $past(sfr_wdata_in[7:2]));
    endproperty
    a_flags_store: assert property (p_flags_store) // [R14]
        else $error("software flags not stored");

    property p_both_halt;
        @(posedge clk_in) disable iff (!rstn_in)
        (s_arm_done and (write_hit && sfr_wdata_in[1:0] == 2'b11 && !sys_reset_out
            && !st_reg.ext_s2 && !wd_expired)) |=> (st_reg.state == LPM_HALT);
    endproperty
    a_both_halt: assert property (p_both_halt) // [R15]
        else $error("both bits did not choose deep halt");

    property p_wdog_in_sleep;
        @(posedge clk_in) disable iff (!rstn_in)
        (wd_expired && st_reg.state == LPM_SLEEP) |=> sys_reset_out && st_reg.state == LPM_RUN;
    endproperty
    a_wdog_in_sleep: assert property (p_wdog_in_sleep) // [R6]
        else $error("watchdog expiry did not end sleep");
endmodule // lpm_power_ctrl

// ===== hw/lpm_wake_if.sv
// Interface between the power controller and its watchdog counter.
// Assumes both ends on clk_in.
`timescale 1ns/1ps
interface lpm_wake_if;
    logic tick;
    logic halted;
    logic enable;
    logic expired;
    modport ctrl (output tick, output halted, output enable, input expired);
    modport wdog (input tick, input halted, input enable, output expired);
endinterface

// ===== hw/lpm_watchdog.sv
// Watchdog counter: counts divided-clock ticks, stops while the chip is halted.
// Assumes tick is a one-cycle enable from the controller's divider.
`timescale 1ns/1ps
module lpm_watchdog #(
    parameter int COUNT_W = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Controller side
    lpm_wake_if.wdog wake
);
    import lpm_pkg::*;

    initial begin
        if (COUNT_W < 2) $error("COUNT_W too small");
    end

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic expired;
    } lpm_wd_type;

    lpm_wd_type st_reg;
    lpm_wd_type st_next;

    always_comb begin
        st_next = st_reg;
        st_next.expired = 1'b0;
        if (!wake.enable) begin
            st_next.count = '0;
        end else if (wake.tick && !wake.halted) begin // [R6]
            if (&st_reg.count) begin
                st_next.expired = 1'b1;
                st_next.count = '0;
            end else begin
                st_next.count = st_reg.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wake.expired = st_reg.expired;
endmodule // lpm_watchdog

// ===== tb/lpm_core_model.sv
// Partner model: the core side that reports instruction completion.
// Assumes the bench asks for one completion per cycle of step_req_in.
`timescale 1ns/1ps
module lpm_core_model (
    // Bench request
    input wire logic step_req_in,
    // Design side
    input wire logic cpu_clk_en_in,
    output logic insn_done_out
);
    // ==========================================
    // Completion
    // A gated core cannot finish instructions, so no completion in sleep or halt
    assign insn_done_out = step_req_in & cpu_clk_en_in;
endmodule // lpm_core_model

// ===== tb/tb_top.sv
// Testbench for the low-power mode controller: register, sleep, halt and wake paths.
// Assumes lpm_pkg and the design files are compiled first; short counts in sim.
`timescale 1ns/1ps
module tb_top;
    import lpm_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic sfr_wr_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [7:0] sfr_rdata_out;
    logic step_req = 1'b0;
    logic insn_done_in;
    logic irq_pending_in = 1'b0;
    logic ext_reset_in = 1'b0;
    logic wdog_enable_in = 1'b0;
    logic lost_clk_enable_in = 1'b0;
    logic cpu_clk_en_out;
    logic periph_clk_en_out;
    logic int_osc_en_out;
    logic sys_reset_out;
    logic [15:0] reset_vector_out;
    logic [2:0] power_state_out;
    int mismatches = 0;
    int checked = 0;
    int n;

    lpm_power_ctrl #(.WDOG_W(4), .LOST_CLK_CYCLES(10)) u_lpm_power_ctrl (
        .clk_in(clk_in), .rstn_in(rstn_in), .sfr_addr_in(sfr_addr_in),
        .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
        .insn_done_in(insn_done_in), .irq_pending_in(irq_pending_in),
        .ext_reset_in(ext_reset_in), .wdog_enable_in(wdog_enable_in),
        .lost_clk_enable_in(lost_clk_enable_in), .cpu_clk_en_out(cpu_clk_en_out),
        .periph_clk_en_out(periph_clk_en_out), .int_osc_en_out(int_osc_en_out),
        .sys_reset_out(sys_reset_out), .reset_vector_out(reset_vector_out),
        .power_state_out(power_state_out));

    lpm_core_model u_lpm_core_model (
        .step_req_in(step_req), .cpu_clk_en_in(cpu_clk_en_out),
        .insn_done_out(insn_done_in));

    // ==========================================
    // Clock, watchdog and closing
    initial begin
        forever #20 clk_in = ~clk_in;
    end

    initial begin
        repeat (5000) @(posedge clk_in);
        mismatches++;
        final_report();
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================
    // Shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk_in);
        #1;
    endtask

    // Write and instruction completion may share one edge; an idle edge follows so that
    // a following write never raises the strobe in the step that lowered it
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d, input logic s);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        step_req = s;
        tick(1);
        sfr_wr_in = 1'b0;
        step_req = 1'b0;
        tick(1);
    endtask

    task automatic wait_reset(input int maxc);
        n = 0;
        while (sys_reset_out !== 1'b1 && n < maxc) begin
            tick(1);
            n++;
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic test_reset();
        check(16'(sfr_rdata_out), 16'(LPM_PWR_CTRL_RESET));
        check(16'(power_state_out), 16'(LPM_RUN));
        check(16'({cpu_clk_en_out, periph_clk_en_out, int_osc_en_out, sys_reset_out}), 16'h000e);
        check(reset_vector_out, LPM_RESET_VECTOR);
        $display("test reset done");
    endtask

    task automatic test_flags();
        sfr_write(LPM_PWR_CTRL_ADDR, 8'hfc, 1'b0);
        check(16'(sfr_rdata_out), 16'h00fc);
        sfr_write(8'h88, 8'h00, 1'b0);
        check(16'(sfr_rdata_out), 16'h00fc);
        sfr_write(LPM_PWR_CTRL_ADDR, 8'h54, 1'b1);
        check(16'(power_state_out), 16'(LPM_RUN));
        check(16'(sfr_rdata_out), 16'h0054);
        $display("test flags done");
    endtask

    task automatic test_sleep();
        sfr_write(LPM_PWR_CTRL_ADDR, 8'h25, 1'b0);
        check(16'(sfr_rdata_out), 16'h0024);
        tick(3);
        check(16'(power_state_out), 16'(LPM_RUN));
        step_req = 1'b1;
        tick(1);
        step_req = 1'b0;
        check(16'(power_state_out), 16'(LPM_SLEEP));
        check(16'({cpu_clk_en_out, periph_clk_en_out, int_osc_en_out}), 16'h0003);
        tick(5);
        check(16'(sfr_rdata_out), 16'h0024);
        irq_pending_in = 1'b1;
        tick(1);
        irq_pending_in = 1'b0;
        check(16'(power_state_out), 16'(LPM_RUN));
        check(16'(cpu_clk_en_out), 16'h0001);
        step_req = 1'b1;
        tick(1);
        step_req = 1'b0;
        check(16'(power_state_out), 16'(LPM_RUN));
        check(16'(sfr_rdata_out), 16'h0024);
        $display("test sleep done");
    endtask

    task automatic test_halt();
        lost_clk_enable_in = 1'b0;
        sfr_write(LPM_PWR_CTRL_ADDR, 8'h03, 1'b1);
        check(16'(power_state_out), 16'(LPM_HALT));
        check(16'({cpu_clk_en_out, periph_clk_en_out, int_osc_en_out}), 16'h0000);
        irq_pending_in = 1'b1;
        tick(4);
        irq_pending_in = 1'b0;
        check(16'(power_state_out), 16'(LPM_HALT));
        ext_reset_in = 1'b1;
        tick(1);
        ext_reset_in = 1'b0;
        wait_reset(6);
        check(16'(sys_reset_out), 16'h0001);
        tick(1);
        check(16'(power_state_out), 16'(LPM_RUN));
        $display("test halt done");
    endtask

    task automatic test_lost_clock();
        lost_clk_enable_in = 1'b1;
        sfr_write(LPM_PWR_CTRL_ADDR, 8'h02, 1'b1);
        check(16'(power_state_out), 16'(LPM_HALT));
        wait_reset(20);
        check(16'(n >= 9 && n <= 13), 16'h0001);
        tick(1);
        check(16'(power_state_out), 16'(LPM_RUN));
        lost_clk_enable_in = 1'b0;
        $display("test lost clock done");
    endtask

    task automatic test_sleep_resets();
        wdog_enable_in = 1'b1;
        sfr_write(LPM_PWR_CTRL_ADDR, 8'h01, 1'b1);
        check(16'(power_state_out), 16'(LPM_SLEEP));
        wait_reset(400);
        check(16'(sys_reset_out), 16'h0001);
        tick(1);
        check(16'(power_state_out), 16'(LPM_RUN));
        wdog_enable_in = 1'b0;
        sfr_write(LPM_PWR_CTRL_ADDR, 8'h01, 1'b1);
        ext_reset_in = 1'b1;
        tick(1);
        ext_reset_in = 1'b0;
        wait_reset(6);
        check(16'(sys_reset_out), 16'h0001);
        tick(1);
        check(16'(power_state_out), 16'(LPM_RUN));
        $display("test sleep resets done");
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        #1;
        check(16'(sfr_rdata_out), 16'h0000);
        rstn_in = 1'b1;
        test_reset();
        test_flags();
        test_sleep();
        test_halt();
        test_lost_clock();
        test_sleep_resets();
        final_report();
    end
endmodule // tb_top
